// >>> rtl/integer_divide_unit.sv
// Integer divide unit: unsigned and signed byte/word division with divide-error trap
`timescale 1ns/10ps
`default_nettype none
`include "div_defs.svh"

// Notes on behaviour
// RULE1: Unsigned word divide: extension:accumulator by 16 bits, quotient acc, remainder ext.
// RULE2: Unsigned word quotient above ffff traps through vector 0, results undefined.
// RULE3: Unsigned word divide also takes its divisor from memory, same placement and trap.
// RULE4: Trap pushes flags at sp-1/2, segment at sp-3/4, counter at sp-5/6.
// RULE5: Trap lowers stack pointer by six, clears interrupt-enable and single-step flags.
// RULE6: Trap loads segment from bytes 3,2 and counter from bytes 1,0.
// RULE7: Signed byte divide: accumulator word by 8 bits, quotient low, remainder high.
// RULE8: Signed byte quotient only within +127 to -127, otherwise trap.
// RULE9: Signed word divide: 32-bit pair by 16 bits, quotient acc, remainder ext.
// RULE10: Signed word quotient only within +32767 to -32767, otherwise trap.
// RULE11: Signed remainder carries the sign of the dividend.
// RULE12: Quotient truncates toward zero.
// RULE13: Signed byte, register divisor: 29 to 34 clocks by data.
// RULE14: Signed byte, memory divisor: 35 to 40 clocks by data.
// RULE15: Signed word, register divisor: 38 to 43 clocks by data.
// RULE16: Signed word, memory: 48 to 53, or 44 to 49 aligned on wide bus.
// RULE17: Unsigned byte divide: quotient low, remainder high, trap above ff.
// RULE18: Arithmetic flags are unspecified after any division.
module integer_divide_unit (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire div_pkg::div_op_e op,
    input wire logic mem_operand,
    input wire logic bus16,
    input wire logic even_addr,
    input wire logic [15:0] accumulator_word,
    input wire logic [15:0] extension_word,
    input wire logic [15:0] divisor,
    input wire logic [15:0] flags_word,
    input wire logic [15:0] code_segment_base,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] stack_pointer,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output var logic busy_r,
    output var logic done_r,
    output var logic trap_r,
    output var logic [15:0] acc_out_r,
    output var logic [15:0] ext_out_r,
    output var logic [15:0] flags_out_r,
    output var logic [15:0] cs_out_r,
    output var logic [15:0] pc_out_r,
    output var logic [15:0] sp_out_r,
    output var logic mem_req_r,
    output var logic mem_we_r,
    output var logic mem_stack_r,
    output var logic [15:0] mem_addr_r,
    output var logic [7:0] mem_wdata_r
);

    // ------------------------------------------------------------
    // Operand preparation at start
    // ------------------------------------------------------------
    div_pkg::div_state_e state_r;
    logic sgn;
    logic word;
    logic take;
    logic [31:0] dvd_raw;
    logic [31:0] dvd_mag;
    logic [15:0] dsr_raw;
    logic [15:0] dsr_mag;
    logic [15:0] hi0;
    logic [15:0] lo0;
    logic dvd_neg;
    logic dsr_neg;
    logic [5:0] base_cyc;
    logic [5:0] total_cyc;

    assign sgn = op[1];
    assign word = op[0];
    assign take = start && (state_r == div_pkg::ST_IDLE);

    always_comb begin
        // RULE1 dividend pair
        dvd_raw = word ? {extension_word, accumulator_word}
                       : {{16{sgn & accumulator_word[15]}}, accumulator_word};
        dvd_neg = sgn & dvd_raw[31];
        // RULE12 magnitude division truncates toward zero
        dvd_mag = dvd_neg ? 32'h0 - dvd_raw : dvd_raw;
        dsr_raw = word ? divisor : {{8{sgn & divisor[7]}}, divisor[7:0]};
        dsr_neg = sgn & dsr_raw[15];
        dsr_mag = dsr_neg ? 16'h0 - dsr_raw : dsr_raw;
        // Byte low half sits at the top so the quotient lands in bits 7:0
        hi0 = word ? dvd_mag[31:16] : {8'h0, dvd_mag[15:8]};
        lo0 = word ? dvd_mag[15:0] : {dvd_mag[7:0], 8'h0};
    end

    always_comb begin
        unique case (op)
            // RULE17 unsigned byte timing
            div_pkg::OP_DIVU8: base_cyc = mem_operand ? `CYC_DIVU8_MEM : `CYC_DIVU8_REG;
            // RULE3 memory divisor form
            div_pkg::OP_DIVU16: base_cyc = !mem_operand ? `CYC_DIVU16_REG :
                                (bus16 && even_addr) ? `CYC_DIVU16_EVEN : `CYC_DIVU16_MEM;
            // RULE13 RULE14 signed byte timing
            div_pkg::OP_DIV8: base_cyc = mem_operand ? `CYC_DIV8_MEM : `CYC_DIV8_REG;
            // RULE15 RULE16 signed word timing
            div_pkg::OP_DIV16: base_cyc = !mem_operand ? `CYC_DIV16_REG :
                               (bus16 && even_addr) ? `CYC_DIV16_EVEN : `CYC_DIV16_MEM;
        endcase
        total_cyc = base_cyc + (dvd_neg ? `CYC_X_DVD_NEG : 6'h0)
                  + (dsr_neg ? `CYC_X_DSR_NEG : 6'h0);
    end

    // ------------------------------------------------------------
    // Shift-subtract divider
    // ------------------------------------------------------------
    logic [15:0] rem_r;
    logic [15:0] quo_r;
    logic [15:0] dsr_r;
    logic [4:0] iter_r;
    logic [5:0] cyc_r;
    logic pre_ovf_r;
    logic sgn_r;
    logic word_r;
    logic dvd_neg_r;
    logic q_neg_r;
    logic [16:0] shifted;
    logic [17:0] diff;

    assign shifted = {rem_r, quo_r[15]};
    assign diff = {1'b0, shifted} - {2'h0, dsr_r};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rem_r <= 16'h0;
            quo_r <= 16'h0;
            dsr_r <= 16'h0;
            iter_r <= 5'h0;
            pre_ovf_r <= 1'b0;
            sgn_r <= 1'b0;
            word_r <= 1'b0;
            dvd_neg_r <= 1'b0;
            q_neg_r <= 1'b0;
        end else if (take) begin
            rem_r <= hi0;
            quo_r <= lo0;
            dsr_r <= dsr_mag;
            iter_r <= word ? `ITER_WORD : `ITER_BYTE;
            // A high half not below the divisor cannot give a quotient that fits
            pre_ovf_r <= (hi0 >= dsr_mag);
            sgn_r <= sgn;
            word_r <= word;
            dvd_neg_r <= dvd_neg;
            q_neg_r <= dvd_neg ^ dsr_neg;
        end else if (state_r == div_pkg::ST_RUN && iter_r != 5'h0 && !pre_ovf_r) begin
            iter_r <= iter_r - 5'h1;
            if (!diff[17]) begin
                rem_r <= diff[15:0];
                quo_r <= {quo_r[14:0], 1'b1};
            end else begin
                rem_r <= shifted[15:0];
                quo_r <= {quo_r[14:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Result forming and range check
    // ------------------------------------------------------------
    logic [15:0] q_s;
    logic [15:0] r_s;
    logic range_ovf;
    logic fault;

    assign q_s = q_neg_r ? 16'h0 - quo_r : quo_r;
    // RULE11 remainder follows the dividend sign
    assign r_s = dvd_neg_r ? 16'h0 - rem_r : rem_r;
    // RULE8 RULE10 magnitude above 7f or 7fff traps, so -128 and -32768 trap too
    assign range_ovf = sgn_r & (word_r ? quo_r[15] : quo_r[7]);
    // RULE2 unsigned overflow, zero divisor included
    assign fault = pre_ovf_r | range_ovf;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    logic [3:0] step_r;
    logic finish;
    logic push_last;
    logic vec_last;

    assign finish = (state_r == div_pkg::ST_RUN) && (cyc_r == 6'h1);
    assign push_last = (state_r == div_pkg::ST_PUSH) && mem_ack && (step_r == `PUSH_LAST);
    assign vec_last = (state_r == div_pkg::ST_VEC) && mem_ack && (step_r == `VEC_LAST);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= div_pkg::ST_IDLE;
            cyc_r <= 6'h0;
        end else begin
            unique case (state_r)
                div_pkg::ST_IDLE: begin
                    if (take) begin
                        state_r <= div_pkg::ST_RUN;
                        cyc_r <= total_cyc;
                    end
                end
                div_pkg::ST_RUN: begin
                    cyc_r <= cyc_r - 6'h1;
                    if (finish) begin
                        state_r <= fault ? div_pkg::ST_PUSH : div_pkg::ST_IDLE;
                    end
                end
                div_pkg::ST_PUSH: begin
                    if (push_last) begin
                        state_r <= div_pkg::ST_VEC;
                    end
                end
                div_pkg::ST_VEC: begin
                    if (vec_last) begin
                        state_r <= div_pkg::ST_IDLE;
                    end
                end
                default: state_r <= div_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else if (take) begin
            busy_r <= 1'b1;
        end else if ((finish && !fault) || vec_last) begin
            busy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Trap memory port
    // ------------------------------------------------------------
    // Indexed by the beat just acked, so it names the word of the next beat
    logic [15:0] push_data;

    always_comb begin
        unique case (step_r)
            4'h0: push_data = flags_word;
            4'h1: push_data = code_segment_base;
            4'h2: push_data = code_segment_base;
            4'h3: push_data = program_counter;
            4'h4: push_data = program_counter;
            default: push_data = program_counter;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            step_r <= 4'h0;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_stack_r <= 1'b0;
            mem_addr_r <= 16'h0;
            mem_wdata_r <= 8'h0;
        end else if (finish && fault) begin
            // RULE4 first push: flags high byte at sp-1
            step_r <= 4'h0;
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b1;
            mem_stack_r <= 1'b1;
            mem_addr_r <= stack_pointer - 16'h1;
            mem_wdata_r <= flags_word[15:8];
        end else if (push_last) begin
            // RULE6 vector fetch starts at byte 0
            step_r <= 4'h0;
            mem_we_r <= 1'b0;
            mem_stack_r <= 1'b0;
            mem_addr_r <= `VEC_BASE;
            mem_wdata_r <= 8'h0;
        end else if (vec_last) begin
            mem_req_r <= 1'b0;
        end else if (mem_req_r && mem_ack) begin
            step_r <= step_r + 4'h1;
            if (state_r == div_pkg::ST_PUSH) begin
                // RULE4 high byte at the odd offset, low byte just below
                mem_addr_r <= mem_addr_r - 16'h1;
                mem_wdata_r <= step_r[0] ? push_data[15:8] : push_data[7:0];
            end else begin
                mem_addr_r <= mem_addr_r + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            done_r <= 1'b0;
            trap_r <= 1'b0;
            acc_out_r <= 16'h0;
            ext_out_r <= 16'h0;
            flags_out_r <= 16'h0;
            cs_out_r <= 16'h0;
            pc_out_r <= 16'h0;
            sp_out_r <= 16'h0;
        end else begin
            done_r <= (finish && !fault) || vec_last;
            trap_r <= vec_last;
            if (finish && !fault) begin
                // RULE7 RULE17 byte: remainder high, quotient low
                // RULE9 word: quotient to acc, remainder to ext
                acc_out_r <= word_r ? q_s : {r_s[7:0], q_s[7:0]};
                ext_out_r <= word_r ? r_s : extension_word;
                // RULE18 flags passed through, callers must not rely on them
                flags_out_r <= flags_word;
                cs_out_r <= code_segment_base;
                pc_out_r <= program_counter;
                sp_out_r <= stack_pointer;
            end else if (state_r == div_pkg::ST_VEC && mem_ack) begin
                // RULE6 bytes 0,1 to counter, 2,3 to segment
                unique case (step_r[1:0])
                    2'h0: pc_out_r[7:0] <= mem_rdata;
                    2'h1: pc_out_r[15:8] <= mem_rdata;
                    2'h2: cs_out_r[7:0] <= mem_rdata;
                    2'h3: cs_out_r[15:8] <= mem_rdata;
                endcase
                if (vec_last) begin
                    // RULE5 stack drops by six, both flags cleared
                    sp_out_r <= stack_pointer - `SP_DROP;
                    flags_out_r <= flags_word & ~((16'h1 << `FLAG_BIT_IE)
                                                | (16'h1 << `FLAG_BIT_STEP));
                    acc_out_r <= accumulator_word;
                    ext_out_r <= extension_word;
                end
            end
        end
    end

endmodule : integer_divide_unit
`default_nettype wire

// >>> shared/div_defs.svh
// Constants of the integer divide unit: cycle counts, flag positions, trap layout
`ifndef DIV_DEFS_SVH
`define DIV_DEFS_SVH

// ------------------------------------------------------------
// Cycle counts from start to done, least value
// ------------------------------------------------------------
`define CYC_DIVU8_REG 6'h13
`define CYC_DIVU8_MEM 6'h19
`define CYC_DIVU16_REG 6'h19
`define CYC_DIVU16_MEM 6'h23
`define CYC_DIVU16_EVEN 6'h1f
`define CYC_DIV8_REG 6'h1d
`define CYC_DIV8_MEM 6'h23
`define CYC_DIV16_REG 6'h26
`define CYC_DIV16_MEM 6'h30
`define CYC_DIV16_EVEN 6'h2c
// Data-dependent additions; both together give the full spread of 5
`define CYC_X_DVD_NEG 6'h02
`define CYC_X_DSR_NEG 6'h03

// ------------------------------------------------------------
// Iterations of the shift-subtract loop
// ------------------------------------------------------------
`define ITER_BYTE 5'h08
`define ITER_WORD 5'h10

// ------------------------------------------------------------
// Flags word bits cleared on the trap
// ------------------------------------------------------------
`define FLAG_BIT_STEP 4
`define FLAG_BIT_IE 9

// ------------------------------------------------------------
// Trap sequence: six stack byte writes, four vector byte reads
// ------------------------------------------------------------
`define PUSH_LAST 4'h5
`define VEC_LAST 4'h3
`define VEC_BASE 16'h0000
`define SP_DROP 16'h0006

`endif

// >>> shared/div_pkg.sv
// Types of the integer divide unit
package div_pkg;

    typedef enum logic [1:0] {
        OP_DIVU8 = 2'h0,
        OP_DIVU16 = 2'h1,
        OP_DIV8 = 2'h2,
        OP_DIV16 = 2'h3
    } div_op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_PUSH = 4'h4,
        ST_VEC = 4'h8
    } div_state_e;

endpackage : div_pkg

// >>> verification/div_mem_model.sv
// Memory partner of the divide unit: acks trap beats, keeps stack bytes, holds the vector
`timescale 1ns/10ps
`default_nettype none
module div_mem_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic mem_req_r,
    input wire logic mem_we_r,
    input wire logic [15:0] mem_addr_r,
    input wire logic [7:0] mem_wdata_r,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    // Stack bytes by low address bits; the bench keeps the stack pointer at 0100
    logic [7:0] st [0:7];
    logic [7:0] vec [0:3] = '{8'h89, 8'h67, 8'h45, 8'h23};
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
    end
    // Slow mode stretches every beat after the first by a cycle
    always @(negedge clk_sys) begin
        mem_ack <= mem_req_r && (!slow || !mem_ack);
        // Released data inverts so a stale byte never looks valid
        mem_rdata <= (mem_req_r && !mem_we_r) ? vec[mem_addr_r[1:0]] : ~mem_rdata;
    end
    always @(posedge clk_sys) begin
        if (mem_req_r && mem_ack && mem_we_r) begin
            st[mem_addr_r[2:0]] <= mem_wdata_r;
        end
    end
endmodule : div_mem_model
`default_nettype wire

// >>> verification/integer_divide_unit_sva.sv
// Port checker of the integer divide unit
`timescale 1ns/10ps
`default_nettype none
module integer_divide_unit_sva (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire div_pkg::div_op_e op,
    input wire logic mem_operand,
    input wire logic bus16,
    input wire logic even_addr,
    input wire logic [15:0] flags_word,
    input wire logic [15:0] stack_pointer,
    input wire logic mem_ack,
    input wire logic busy_r,
    input wire logic done_r,
    input wire logic trap_r,
    input wire logic [15:0] flags_out_r,
    input wire logic [15:0] sp_out_r,
    input wire logic mem_req_r,
    input wire logic mem_we_r,
    input wire logic mem_stack_r,
    input wire logic [15:0] mem_addr_r,
    input wire logic [7:0] mem_wdata_r
);
    // ------------------------------------------------------------
    // Cycle count since the request was taken
    // ------------------------------------------------------------
    logic [7:0] cyc_r;
    div_pkg::div_op_e op_r;
    logic [2:0] mode_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cyc_r <= 8'h00;
            op_r <= div_pkg::OP_DIVU8;
            mode_r <= 3'h0;
        end else if (start && !busy_r) begin
            cyc_r <= 8'h00;
            op_r <= op;
            mode_r <= {mem_operand, bus16, even_addr};
        end else if (busy_r) begin
            cyc_r <= cyc_r + 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence taken;
        start && !busy_r;
    endsequence
    sequence ok_end;
        done_r && !trap_r;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_BUSY: assert property (taken |=> busy_r)
        else $error("busy not raised");
    AST_TRAP_PULSE: assert property (trap_r |-> done_r ##1 !trap_r)
        else $error("trap pulse wrong");
    AST_PUSH_FIRST: assert property ($rose(mem_req_r) |-> mem_we_r && mem_stack_r
        && mem_addr_r == stack_pointer - 16'h0001 && mem_wdata_r == flags_word[15:8])
        else $error("first push wrong");
    AST_BEAT_HOLD: assert property (mem_req_r && !mem_ack |=> mem_req_r
        && $stable(mem_addr_r) && $stable(mem_wdata_r)) else $error("beat not held");
    AST_SP_TRAP: assert property (trap_r |-> sp_out_r == stack_pointer - 16'h0006)
        else $error("stack pointer wrong");
    AST_FLAGS_CLR: assert property (trap_r |-> !flags_out_r[9] && !flags_out_r[4])
        else $error("flags not cleared");
    AST_VEC_READ: assert property (mem_req_r && !mem_we_r |-> !mem_stack_r
        && mem_addr_r < 16'h0004) else $error("vector read wrong");
    AST_DIV8_REG: assert property ((ok_end and (op_r == div_pkg::OP_DIV8 && !mode_r[2]))
        |-> cyc_r inside {[29:34]}) else $error("byte reg time");
    AST_DIV8_MEM: assert property ((ok_end and (op_r == div_pkg::OP_DIV8 && mode_r[2]))
        |-> cyc_r inside {[35:40]}) else $error("byte mem time");
    AST_DIV16_REG: assert property ((ok_end and (op_r == div_pkg::OP_DIV16 && !mode_r[2]))
        |-> cyc_r inside {[38:43]}) else $error("word reg time");
    AST_DIV16_MEM: assert property ((ok_end and (op_r == div_pkg::OP_DIV16 && mode_r[2]))
        |-> (mode_r[1:0] == 2'h3 ? cyc_r inside {[44:49]} : cyc_r inside {[48:53]}))
        else $error("word mem time");
endmodule : integer_divide_unit_sva
bind integer_divide_unit integer_divide_unit_sva chk (.*);
`default_nettype wire

// >>> verification/integer_divide_unit_tb_top.sv
// Self-checking bench of the integer divide unit
`timescale 1ns/10ps
`default_nettype none
module integer_divide_unit_tb_top;
    logic clk_sys, resetn, start, mem_operand, bus16, even_addr, mem_ack, slow;
    div_pkg::div_op_e op;
    logic [15:0] accumulator_word, extension_word, divisor, flags_word;
    logic [15:0] code_segment_base, program_counter, stack_pointer;
    logic [7:0] mem_rdata, mem_wdata_r;
    logic busy_r, done_r, trap_r, mem_req_r, mem_we_r, mem_stack_r;
    logic [15:0] acc_out_r, ext_out_r, flags_out_r, cs_out_r, pc_out_r, sp_out_r, mem_addr_r;
    int err_count = 0;
    int checks = 0;
    integer_divide_unit dut (.*);
    div_mem_model mem (.*);
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic close_out;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // One divide; n is the expected cycle count, zero where a trap is expected
    task automatic run(input logic [1:0] o, input logic [2:0] m, input logic [47:0] dv,
        input logic [31:0] exp, input logic [7:0] n);
        int k;
        @(negedge clk_sys);
        op = div_pkg::div_op_e'(o);
        {mem_operand, bus16, even_addr} = m;
        {extension_word, accumulator_word, divisor} = dv;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        // Counted from the edge that took the request
        k = 0;
        while (done_r !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            k++;
        end
        cmp(16'(done_r), 16'h0001);
        cmp(16'(trap_r), 16'(n == 8'h00));
        if (n != 8'h00) begin
            cmp(16'(k), 16'(n));
            cmp(acc_out_r, exp[31:16]);
            cmp(ext_out_r, exp[15:0]);
        end
    endtask : run
    task automatic t_divu8;
        run(2'h0, 3'h0, 48'h0000_00cc_000a, 32'h0414_0000, 8'h13);
        run(2'h0, 3'h0, 48'h0000_0100_0001, 32'h0, 8'h00);
    endtask : t_divu8
    task automatic t_divu16;
        run(2'h1, 3'h0, 48'h0348_2197_2000, 32'h1a41_0197, 8'h19);
        run(2'h1, 3'h0, 48'h0000_ffff_0001, 32'hffff_0000, 8'h19);
        run(2'h1, 3'h0, 48'h0001_0000_0001, 32'h0, 8'h00);
        run(2'h1, 3'h7, 48'h0000_0064_0005, 32'h0014_0000, 8'h1f);
        run(2'h1, 3'h4, 48'h0000_0064_0000, 32'h0, 8'h00);
    endtask : t_divu16
    task automatic t_div8;
        run(2'h2, 3'h0, 48'h0000_ff09_0003, 32'hffae_0000, 8'h1f);
        run(2'h2, 3'h4, 48'h0000_04d2_00ec, 32'h0ec3_0000, 8'h26);
        run(2'h2, 3'h0, 48'h0000_007f_0001, 32'h007f_0000, 8'h1d);
        run(2'h2, 3'h0, 48'h0000_ff81_0001, 32'h0081_0000, 8'h1f);
        run(2'h2, 3'h0, 48'h0000_ff80_0001, 32'h0, 8'h00);
        run(2'h2, 3'h0, 48'h0000_fff9_0002, 32'hfffd_0000, 8'h1f);
    endtask : t_div8
    task automatic t_div16;
        run(2'h3, 3'h0, 48'h0123_4567_1000, 32'h1234_0567, 8'h26);
        run(2'h3, 3'h7, 48'hffff_ffde_fffe, 32'h0011_0000, 8'h31);
        run(2'h3, 3'h4, 48'hffff_8001_0001, 32'h8001_0000, 8'h32);
        run(2'h3, 3'h0, 48'hffff_fff9_0002, 32'hfffd_ffff, 8'h28);
        run(2'h3, 3'h0, 48'hffff_8000_0001, 32'h0, 8'h00);
        run(2'h3, 3'h0, 48'h0000_8000_0001, 32'h0, 8'h00);
    endtask : t_div16
    task automatic t_trap;
        slow = 1'b1;
        run(2'h1, 3'h0, 48'h0000_1234_0000, 32'h0, 8'h00);
        cmp({mem.st[7], mem.st[6]}, flags_word);
        cmp({mem.st[5], mem.st[4]}, code_segment_base);
        cmp({mem.st[3], mem.st[2]}, program_counter);
        cmp(sp_out_r, 16'h00fa);
        cmp(flags_out_r & 16'h0210, 16'h0000);
        cmp(cs_out_r, 16'h2345);
        cmp(pc_out_r, 16'h6789);
        slow = 1'b0;
    endtask : t_trap
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Whole run is near 780 cycles
    initial begin
        #(4000 * 50);
        err_count++;
        close_out();
    end
    initial begin
        resetn = 1'b0;
        {mem_operand, bus16, even_addr, start, slow} = 5'h00;
        op = div_pkg::OP_DIVU8;
        {accumulator_word, extension_word, divisor} = 48'h0;
        flags_word = 16'h0a15;
        code_segment_base = 16'h1357;
        program_counter = 16'h2468;
        stack_pointer = 16'h0100;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        t_divu8();
        t_divu16();
        t_div8();
        t_div16();
        t_trap();
        close_out();
    end
endmodule : integer_divide_unit_tb_top
`default_nettype wire
